// ==== tfg_pkg.sv ====
`default_nettype none

package tfg_pkg;

    // ----------------------------------------------------------------
    // Register offsets
    // ----------------------------------------------------------------
    localparam logic [15:0] TFG_OFF_ENABLE   = 16'h8020;
    localparam logic [15:0] TFG_OFF_CONTROL  = 16'h8021;
    localparam logic [15:0] TFG_OFF_ENDLESS  = 16'h8022;
    localparam logic [15:0] TFG_OFF_IRQ_EN   = 16'h8023;
    localparam logic [15:0] TFG_OFF_PAY_LEN  = 16'h8025;
    localparam logic [15:0] TFG_OFF_GAP_LEN  = 16'h8026;
    localparam logic [15:0] TFG_OFF_CNT_UP   = 16'h8027;
    localparam logic [15:0] TFG_OFF_CNT_LOW  = 16'h8028;
    localparam logic [15:0] TFG_OFF_DONE     = 16'h8029;

    // ----------------------------------------------------------------
    // Field positions and reset values
    // ----------------------------------------------------------------
    localparam int          TFG_BIT_RESTART  = 3;
    localparam logic [2:0]  TFG_RST_PATTERN  = 3'h1;
    localparam logic [15:0] TFG_RST_PAY_LEN  = 16'h006b;
    localparam logic [15:0] TFG_RST_GAP_LEN  = 16'h000c;
    localparam logic [15:0] TFG_RST_CNT_UP   = 16'h0000;
    localparam logic [15:0] TFG_RST_CNT_LOW  = 16'h0100;

    // ----------------------------------------------------------------
    // Payload pattern codes
    // ----------------------------------------------------------------
    localparam logic [2:0]  TFG_PAT_STOP     = 3'h0;
    localparam logic [2:0]  TFG_PAT_RANDOM   = 3'h1;
    localparam logic [2:0]  TFG_PAT_ZEROS    = 3'h2;
    localparam logic [2:0]  TFG_PAT_ONES     = 3'h3;
    localparam logic [2:0]  TFG_PAT_FIVES    = 3'h4;
    localparam logic [2:0]  TFG_PAT_DOWN     = 3'h5;
    localparam logic [7:0]  TFG_BYTE_FIVES   = 8'h55;
    localparam logic [7:0]  TFG_BYTE_TOP     = 8'hff;

    // ----------------------------------------------------------------
    // Frame layout, checksum and buffering
    // ----------------------------------------------------------------
    localparam logic [15:0] TFG_ADDR_LAST    = 16'h0005;
    localparam logic [15:0] TFG_LEN_LAST     = 16'h0001;
    localparam logic [15:0] TFG_FCS_LAST     = 16'h0003;
    // Addresses are arbitrary locally administered values
    localparam logic [47:0] TFG_DEST_ADDR    = 48'h02_00_00_00_00_01;
    localparam logic [47:0] TFG_SRC_ADDR     = 48'h02_00_00_00_00_02;
    localparam logic [31:0] TFG_CRC_INIT     = 32'hffffffff;
    localparam logic [31:0] TFG_CRC_POLY     = 32'hedb88320;
    localparam logic [31:0] TFG_LFSR_SEED    = 32'h0000_0001;
    localparam logic [31:0] TFG_LFSR_TAPS    = 32'h8020_0003;
    localparam int          TFG_FIFO_WIDTH   = 9;
    localparam int          TFG_FIFO_DEPTH   = 4;

    typedef enum logic [2:0] {
        TFG_ST_IDLE = 3'b000,
        TFG_ST_DEST = 3'b001,
        TFG_ST_SRC  = 3'b010,
        TFG_ST_LEN  = 3'b011,
        TFG_ST_DATA = 3'b100,
        TFG_ST_FCS  = 3'b101,
        TFG_ST_GAP  = 3'b110
    } tfg_state_t;

endpackage

`default_nettype wire

// ==== tfg_top.sv ====
`timescale 1ns/1ps
`default_nettype none

module tfg_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 4
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             clr,
    // Fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW:0]                 wp;
        logic [AW:0]                 rp;
    } tfg_fifo_state_t;

    tfg_fifo_state_t s_q;
    tfg_fifo_state_t s_d;
    logic            full;
    logic            empty;

    always_comb
    begin
        s_d       = s_q;
        empty     = (s_q.wp == s_q.rp);
        full      = (s_q.wp[AW] != s_q.rp[AW])
                    && (s_q.wp[AW-1:0] == s_q.rp[AW-1:0]);
        in_ready  = !full;
        out_valid = !empty;
        out_data  = s_q.mem[s_q.rp[AW-1:0]];
        if (clr)
        begin
            s_d.wp = '0;
            s_d.rp = '0;
        end
        else
        begin
            if (in_valid && !full)
            begin
                s_d.mem[s_q.wp[AW-1:0]] = in_data;
                s_d.wp = s_q.wp + 1'b1;
            end
            if (out_ready && !empty)
            begin
                s_d.rp = s_q.rp + 1'b1;
            end
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end
endmodule

module tfg_top
    import tfg_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // Management register port
    input  wire logic [15:0] reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [15:0] reg_rdata,
    output logic             reg_rvalid,
    // Transmit bytes from the MAC interface
    input  wire logic        mac_tx_en,
    input  wire logic [7:0]  mac_txd,
    // Transmit bytes toward the PHY, one per strobe
    input  wire logic        phy_tx_strobe,
    output logic             phy_tx_en,
    output logic      [7:0]  phy_txd,
    // Completion event toward the subsystem interrupt status
    output logic             completion_irq
);
    import tfg_pkg::*;

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic        en;
        logic [2:0]  pattern;
        logic        endless;
        logic        irq_en;
        logic [15:0] pay_len;
        logic [15:0] gap_len;
        logic [15:0] cnt_up;
        logic [15:0] cnt_low;
        logic        done;
        logic        running;
        logic [31:0] remaining;
        tfg_state_t  st;
        logic [15:0] idx;
        logic [31:0] crc;
        logic [31:0] lfsr;
        logic [15:0] rdata;
        logic        rvalid;
        logic        irq;
        logic        tx_en;
        logic [7:0]  txd;
    } tfg_top_state_t;

    tfg_top_state_t s_q;
    tfg_top_state_t s_d;

    logic       gen_valid;
    logic       gen_ready;
    logic [8:0] gen_data;
    logic       buf_valid;
    logic       buf_ready;
    logic [8:0] buf_data;

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic [31:0] crc_byte(logic [31:0] c, logic [7:0] b);
        logic [31:0] r;
        r = c ^ {24'h000000, b};
        for (int i = 0; i < 8; i++)
        begin
            r = r[0] ? ((r >> 1) ^ TFG_CRC_POLY) : (r >> 1);
        end
        return r;
    endfunction

    function automatic logic [7:0] addr_byte(logic [47:0] a, logic [15:0] i);
        logic [47:0] sh;
        sh = a >> {3'h5 - i[2:0], 3'h0};
        return sh[7:0];
    endfunction

    // Byte buffer decouples generation from the PHY byte pacing
    tfg_fifo #(
        .WIDTH (TFG_FIFO_WIDTH),
        .DEPTH (TFG_FIFO_DEPTH)
    ) u_fifo (
        .clk       (clk),
        .rst       (rst),
        .clr       (!s_q.en),
        .in_valid  (gen_valid),
        .in_ready  (gen_ready),
        .in_data   (gen_data),
        .out_valid (buf_valid),
        .out_ready (buf_ready),
        .out_data  (buf_data)
    );

    assign buf_ready = phy_tx_strobe && s_q.en;

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb
    begin
        logic        start;
        logic        last;
        logic [7:0]  pay;
        logic [31:0] fcs;
        logic [31:0] fcs_sh;
        start     = 1'b0;
        last      = 1'b0;
        pay       = 8'h00;
        fcs       = ~s_q.crc;
        fcs_sh    = fcs >> {s_q.idx[1:0], 3'h0};
        s_d       = s_q;
        s_d.rvalid = 1'b0;
        s_d.irq   = 1'b0;

        // Register writes
        if (reg_wr)
        begin
            unique case (reg_addr)
                TFG_OFF_ENABLE:
                begin
                    start    = reg_wdata[0] && !s_q.en;
                    s_d.en   = reg_wdata[0];
                end
                TFG_OFF_CONTROL:
                begin
                    s_d.pattern = reg_wdata[2:0];
                    start = reg_wdata[TFG_BIT_RESTART] && s_q.en;
                end
                TFG_OFF_ENDLESS: s_d.endless = reg_wdata[0];
                TFG_OFF_IRQ_EN:  s_d.irq_en  = reg_wdata[0];
                TFG_OFF_PAY_LEN: s_d.pay_len = reg_wdata;
                TFG_OFF_GAP_LEN: s_d.gap_len = reg_wdata;
                TFG_OFF_CNT_UP:  s_d.cnt_up  = reg_wdata;
                TFG_OFF_CNT_LOW: s_d.cnt_low = reg_wdata;
                default:
                begin
                end
            endcase
        end

        // Register reads; the restart bit always reads zero
        if (reg_rd)
        begin
            s_d.rvalid = 1'b1;
            unique case (reg_addr)
                TFG_OFF_ENABLE:  s_d.rdata = {15'h0000, s_q.en};
                TFG_OFF_CONTROL: s_d.rdata = {13'h0000, s_q.pattern};
                TFG_OFF_ENDLESS: s_d.rdata = {15'h0000, s_q.endless};
                TFG_OFF_IRQ_EN:  s_d.rdata = {15'h0000, s_q.irq_en};
                TFG_OFF_PAY_LEN: s_d.rdata = s_q.pay_len;
                TFG_OFF_GAP_LEN: s_d.rdata = s_q.gap_len;
                TFG_OFF_CNT_UP:  s_d.rdata = s_q.cnt_up;
                TFG_OFF_CNT_LOW: s_d.rdata = s_q.cnt_low;
                TFG_OFF_DONE:
                begin
                    s_d.rdata = {15'h0000, s_q.done};
                    s_d.done  = 1'b0;
                end
                default:         s_d.rdata = 16'h0000;
            endcase
        end

        // Payload byte for the current position
        unique case (s_q.pattern)
            TFG_PAT_RANDOM: pay = s_q.lfsr[7:0];
            TFG_PAT_ONES:   pay = 8'hff;
            TFG_PAT_FIVES:  pay = TFG_BYTE_FIVES;
            TFG_PAT_DOWN:   pay = TFG_BYTE_TOP - s_q.idx[7:0];
            default:        pay = 8'h00;
        endcase

        // Frame byte offered to the buffer; gap bytes carry enable low
        gen_valid = s_q.st != TFG_ST_IDLE;
        unique case (s_q.st)
            TFG_ST_DEST: gen_data = {1'b1, addr_byte(TFG_DEST_ADDR, s_q.idx)};
            TFG_ST_SRC:  gen_data = {1'b1, addr_byte(TFG_SRC_ADDR, s_q.idx)};
            TFG_ST_LEN:  gen_data = {1'b1, s_q.idx[0] ? s_q.pay_len[7:0]
                                                      : s_q.pay_len[15:8]};
            TFG_ST_DATA: gen_data = {1'b1, pay};
            TFG_ST_FCS:  gen_data = {1'b1, fcs_sh[7:0]};
            default:     gen_data = 9'h000;
        endcase

        // Generator sequencing, stalled by a full buffer
        if (!s_q.en)
        begin
            s_d.st      = TFG_ST_IDLE;
            s_d.running = 1'b0;
            s_d.idx     = 16'h0000;
        end
        else if (s_q.st == TFG_ST_IDLE)
        begin
            if (s_q.running && (s_q.pattern != TFG_PAT_STOP))
            begin
                s_d.st  = TFG_ST_DEST;
                s_d.idx = 16'h0000;
                s_d.crc = TFG_CRC_INIT;
            end
        end
        else if (gen_ready)
        begin
            s_d.idx = s_q.idx + 16'h0001;
            if (s_q.st != TFG_ST_FCS && s_q.st != TFG_ST_GAP)
            begin
                s_d.crc = crc_byte(s_q.crc, gen_data[7:0]);
            end
            if (s_q.st == TFG_ST_DATA)
            begin
                s_d.lfsr = s_q.lfsr[0] ? ((s_q.lfsr >> 1) ^ TFG_LFSR_TAPS)
                                       : (s_q.lfsr >> 1);
            end
            unique case (s_q.st)
                TFG_ST_DEST, TFG_ST_SRC: last = s_q.idx == TFG_ADDR_LAST;
                TFG_ST_LEN:  last = s_q.idx == TFG_LEN_LAST;
                TFG_ST_DATA: last = s_q.idx == s_q.pay_len - 16'h0001;
                TFG_ST_FCS:  last = s_q.idx == TFG_FCS_LAST;
                default:     last = s_q.idx == s_q.gap_len - 16'h0001;
            endcase
            if (last)
            begin
                s_d.idx = 16'h0000;
                unique case (s_q.st)
                    TFG_ST_DEST: s_d.st = TFG_ST_SRC;
                    TFG_ST_SRC:  s_d.st = TFG_ST_LEN;
                    TFG_ST_LEN:  s_d.st = (s_q.pay_len != 16'h0000)
                                          ? TFG_ST_DATA : TFG_ST_FCS;
                    TFG_ST_DATA: s_d.st = TFG_ST_FCS;
                    TFG_ST_FCS:
                    begin
                        s_d.st = (s_q.gap_len != 16'h0000)
                                 ? TFG_ST_GAP : TFG_ST_IDLE;
                        if (!s_q.endless)
                        begin
                            s_d.remaining = s_q.remaining - 32'h00000001;
                            if (s_q.remaining == 32'h00000001)
                            begin
                                s_d.running = 1'b0;
                                s_d.done    = 1'b1;
                                s_d.irq     = s_q.irq_en;
                            end
                        end
                    end
                    default:     s_d.st = TFG_ST_IDLE;
                endcase
            end
        end

        // Enable or restart reloads the count and returns to idle; a zero count without endless mode flags done at once
        if (start)
        begin
            s_d.remaining = {s_q.cnt_up, s_q.cnt_low};
            s_d.st        = TFG_ST_IDLE;
            s_d.idx       = 16'h0000;
            s_d.running   = s_q.endless || ({s_q.cnt_up, s_q.cnt_low} != '0);
            if (!s_q.endless && ({s_q.cnt_up, s_q.cnt_low} == '0))
            begin
                s_d.done = 1'b1;
                s_d.irq  = s_q.irq_en;
            end
        end

        // Output byte stage, advanced once per PHY byte strobe
        if (phy_tx_strobe)
        begin
            if (s_q.en)
            begin
                s_d.tx_en = buf_valid && buf_data[8];
                s_d.txd   = buf_valid ? buf_data[7:0] : 8'h00;
            end
            else
            begin
                s_d.tx_en = mac_tx_en;
                s_d.txd   = mac_txd;
            end
        end
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            s_q         <= '0;
            s_q.pattern <= TFG_RST_PATTERN;
            s_q.pay_len <= TFG_RST_PAY_LEN;
            s_q.gap_len <= TFG_RST_GAP_LEN;
            s_q.cnt_up  <= TFG_RST_CNT_UP;
            s_q.cnt_low <= TFG_RST_CNT_LOW;
            s_q.crc     <= TFG_CRC_INIT;
            s_q.lfsr    <= TFG_LFSR_SEED;
            s_q.st      <= TFG_ST_IDLE;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign reg_rdata      = s_q.rdata;
    assign reg_rvalid     = s_q.rvalid;
    assign phy_tx_en      = s_q.tx_en;
    assign phy_txd        = s_q.txd;
    assign completion_irq = s_q.irq;
endmodule

`default_nettype wire

// ==== tfg_top_chk.sv ====
`timescale 1ns/1ps
`default_nettype none

module tfg_chk
    import tfg_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // Register port
    input  wire logic [15:0] reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [15:0] reg_rdata,
    input  wire logic        reg_rvalid,
    // Transmit path
    input  wire logic        mac_tx_en,
    input  wire logic [7:0]  mac_txd,
    input  wire logic        phy_tx_strobe,
    input  wire logic        phy_tx_en,
    input  wire logic [7:0]  phy_txd,
    input  wire logic        completion_irq
);
    logic en_q;
    logic irq_en_q;
    logic done_q;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    // --------------------
    // Shadow bits of what software wrote, and of the done flag set by the irq
    // --------------------
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            en_q     <= 1'b0;
            irq_en_q <= 1'b0;
            done_q   <= 1'b0;
        end
        else
        begin
            if (reg_wr && reg_addr == TFG_OFF_ENABLE)
                en_q <= reg_wdata[0];
            if (reg_wr && reg_addr == TFG_OFF_IRQ_EN)
                irq_en_q <= reg_wdata[0];
            if (completion_irq)
                done_q <= 1'b1;
            else if (reg_rd && reg_addr == TFG_OFF_DONE)
                done_q <= 1'b0;
        end
    end

    a_rvalid_after_rd:
        assert property (reg_rd |=> reg_rvalid)
        else $error("read without valid");
    a_rvalid_needs_rd:
        assert property (reg_rvalid |-> $past(reg_rd))
        else $error("valid without read");
    a_rdata_holds:
        assert property (!reg_rd |=> $stable(reg_rdata))
        else $error("read data moved");
    a_restart_self_clear:
        assert property (reg_rd && reg_addr == TFG_OFF_CONTROL
                         |=> reg_rdata[15:3] == 13'h0000)
        else $error("restart bit stuck");
    a_enable_readback:
        assert property (reg_rd && reg_addr == TFG_OFF_ENABLE
                         |=> reg_rdata == {15'h0000, en_q})
        else $error("enable readback wrong");
    a_done_reads_one:
        assert property (reg_rd && reg_addr == TFG_OFF_DONE && done_q
                         |=> reg_rdata == 16'h0001)
        else $error("done flag lost");
    a_irq_one_pulse:
        assert property (completion_irq |=> !completion_irq)
        else $error("irq longer than one cycle");
    a_irq_needs_en:
        assert property (completion_irq |-> irq_en_q)
        else $error("irq while disabled");
    a_mac_passes:
        assert property (phy_tx_strobe && !en_q && !$past(en_q)
                         |=> phy_tx_en == $past(mac_tx_en)
                             && phy_txd == $past(mac_txd))
        else $error("mac byte not passed");
    a_tx_holds:
        assert property (!phy_tx_strobe && !reg_wr
                         |=> $stable(phy_tx_en) && $stable(phy_txd))
        else $error("tx byte moved without strobe");

endmodule

`default_nettype wire

// ==== tfg_phy_model.sv ====
`timescale 1ns/1ps
`default_nettype none

module tfg_phy_model (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // Pacing: every cycle, or every other one
    input  wire logic slow,
    // Byte request toward the generator
    output logic      phy_tx_strobe
);
    logic tick_q;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            tick_q        <= 1'b0;
            phy_tx_strobe <= 1'b0;
        end
        else
        begin
            tick_q        <= ~tick_q;
            phy_tx_strobe <= !slow || tick_q;
        end
    end

endmodule

`default_nettype wire

// ==== tb.sv ====
`timescale 1ns/1ps
`default_nettype none

module tb;
    import tfg_pkg::*;
    typedef struct packed {
        logic [15:0] a;
        logic [15:0] d;
        logic [15:0] e;
    } tfg_row_t;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [15:0] reg_addr;
    logic [15:0] reg_wdata;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [15:0] reg_rdata;
    logic        reg_rvalid;
    logic        mac_tx_en = 1'b0;
    logic [7:0]  mac_txd = 8'h00;
    logic        phy_tx_strobe;
    logic        phy_tx_en;
    logic [7:0]  phy_txd;
    logic        completion_irq;
    logic        slow = 1'b0;
    logic        strb_d = 1'b0;
    logic        prev_en = 1'b0;
    logic        irq_mask = 1'b1;
    logic [7:0]  rx[$];
    logic [15:0] v;
    int          n_errors = 0;
    int          n_compared = 0;
    int          n_frm = 0;
    int          n_irq = 0;
    int          gap_run = 0;
    int          last_gap = 0;
    tfg_row_t    rows [16];

    always #10 clk = ~clk;

    tfg_top u_tfg_top (.clk(clk), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .mac_tx_en(mac_tx_en), .mac_txd(mac_txd),
        .phy_tx_strobe(phy_tx_strobe), .phy_tx_en(phy_tx_en),
        .phy_txd(phy_txd), .completion_irq(completion_irq));
    tfg_phy_model u_tfg_phy_model (.clk(clk), .rst(rst), .slow(slow),
        .phy_tx_strobe(phy_tx_strobe));

    // --------------------
    // Byte monitor: a byte stands in the cycle after its strobe
    // --------------------
    always @(posedge clk)
    begin
        strb_d <= phy_tx_strobe;
        if (completion_irq && irq_mask)
            n_irq <= n_irq + 1;
        if (strb_d)
        begin
            prev_en <= phy_tx_en;
            if (phy_tx_en)
            begin
                rx.push_back(phy_txd);
                if (!prev_en)
                begin
                    n_frm    <= n_frm + 1;
                    last_gap <= gap_run;
                end
                gap_run <= 0;
            end
            else
                gap_run <= gap_run + 1;
        end
    end

    // --------------------
    // Shared tasks
    // --------------------
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr    <= 1'b0;
    endtask

    task automatic rd(input logic [15:0] a);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd   <= 1'b0;
        #1;
        chk({15'h0000, reg_rvalid}, 16'h0001);
        v = reg_rdata;
    endtask

    function automatic logic [31:0] crc_step(logic [31:0] c, logic [7:0] b);
        logic [31:0] r;
        r = c ^ {24'h000000, b};
        for (int k = 0; k < 8; k++)
            r = r[0] ? (r >> 1) ^ TFG_CRC_POLY : r >> 1;
        return r;
    endfunction

    function automatic logic [7:0] pay(input logic [2:0] p, input int i);
        case (p)
            TFG_PAT_ONES:  return 8'hff;
            TFG_PAT_FIVES: return TFG_BYTE_FIVES;
            TFG_PAT_DOWN:  return 8'(255 - (i % 256));
            default:       return 8'h00;
        endcase
    endfunction

    // Random payload is checked only through the FCS
    task automatic check_frames(input logic [2:0] p, input int cnt);
        int          b;
        logic [31:0] c;
        logic [7:0]  e;
        logic [111:0] hdr = {TFG_DEST_ADDR, TFG_SRC_ADDR, 16'h0004};
        chk(16'(rx.size()), 16'(cnt * 22));
        for (int f = 0; f < cnt && rx.size() >= cnt * 22; f++)
        begin
            b = f * 22;
            c = TFG_CRC_INIT;
            for (int i = 0; i < 18; i++)
            begin
                e = i < 14 ? hdr[111 - 8 * i -: 8] : pay(p, i - 14);
                if (i < 14 || p != TFG_PAT_RANDOM)
                    chk({8'h00, rx[b+i]}, {8'h00, e});
                c = crc_step(c, rx[b + i]);
            end
            c = ~c;
            for (int i = 0; i < 4; i++)
                chk({8'h00, rx[b+18+i]}, {8'h00, c[8*i+:8]});
        end
    endtask

    task automatic start(input logic [2:0] p, input logic [15:0] cnt);
        wr(TFG_OFF_ENABLE, 16'h0000);
        wr(TFG_OFF_CNT_LOW, cnt);
        wr(TFG_OFF_CONTROL, {13'h0000, p});
        #1;
        rx.delete();
        n_frm = 0;
        n_irq = 0;
        wr(TFG_OFF_ENABLE, 16'h0001);
    endtask

    task automatic settle(input int n);
        for (int k = 0; k < 3000 && n_frm < n; k++)
            @(posedge clk);
        chk(16'(n_frm >= n), 16'h0001);
        repeat (80) @(posedge clk);
        #1;
    endtask

    task automatic verify(input logic [2:0] p, input int cnt, input int irqs);
        check_frames(p, cnt);
        chk(16'(n_frm), 16'(cnt));
        if (cnt > 1)
            chk(16'(last_gap), 16'h0003);
        chk(16'(n_irq), 16'(irqs));
        rd(TFG_OFF_DONE);
        chk(v, 16'h0001);
        rd(TFG_OFF_DONE);
        chk(v, 16'h0000);
    endtask

    task automatic test_done(input string name);
        $display("test %s finished at %0t", name, $time);
    endtask

    task automatic end_sim;
        $display("compared %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    initial
    begin
        repeat (20000) @(posedge clk);
        n_errors++;
        end_sim;
    end

    // --------------------
    // Main sequence
    // --------------------
    initial
    begin
        // Rows with zero data are read-only checks
        rows = '{
            '{TFG_OFF_ENABLE, 16'h0000, 16'h0000},
            '{TFG_OFF_CONTROL, 16'h0000, 16'h0001},
            '{TFG_OFF_ENDLESS, 16'h0000, 16'h0000},
            '{TFG_OFF_IRQ_EN, 16'h0000, 16'h0000},
            '{TFG_OFF_PAY_LEN, 16'h0000, 16'h006b},
            '{TFG_OFF_GAP_LEN, 16'h0000, 16'h000c},
            '{TFG_OFF_CNT_UP, 16'h0000, 16'h0000},
            '{TFG_OFF_CNT_LOW, 16'h0000, 16'h0100},
            '{TFG_OFF_DONE, 16'h0000, 16'h0000},
            '{16'h8024, 16'hffff, 16'h0000},
            '{TFG_OFF_PAY_LEN, 16'h0004, 16'h0004},
            '{TFG_OFF_GAP_LEN, 16'h0003, 16'h0003},
            '{TFG_OFF_IRQ_EN, 16'hffff, 16'h0001},
            '{TFG_OFF_CONTROL, 16'h000d, 16'h0005},
            '{TFG_OFF_DONE, 16'hffff, 16'h0000},
            '{TFG_OFF_ENDLESS, 16'h0002, 16'h0000}};
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        foreach (rows[i])
        begin
            if (rows[i].d != 16'h0000)
                wr(rows[i].a, rows[i].d);
            rd(rows[i].a);
            chk(v, rows[i].e);
        end
        test_done("registers");
        @(posedge clk);
        mac_tx_en <= 1'b1;
        mac_txd   <= 8'ha5;
        repeat (3) @(posedge clk);
        #1;
        chk({7'h00, phy_tx_en, phy_txd}, 16'h01a5);
        @(posedge clk);
        mac_tx_en <= 1'b0;
        slow      <= 1'b1;
        test_done("mac path");
        for (int p = 1; p < 6; p++)
        begin
            start(3'(p), 16'h0002);
            settle(2);
            verify(3'(p), 2, 1);
        end
        test_done("patterns");
        rx.delete();
        n_frm = 0;
        n_irq = 0;
        wr(TFG_OFF_CONTROL, 16'h000d);
        settle(2);
        verify(TFG_PAT_DOWN, 2, 1);
        test_done("restart");
        wr(TFG_OFF_IRQ_EN, 16'h0000);
        start(TFG_PAT_ZEROS, 16'h0001);
        settle(1);
        verify(TFG_PAT_ZEROS, 1, 0);
        test_done("irq off");
        wr(TFG_OFF_ENDLESS, 16'h0001);
        start(TFG_PAT_ONES, 16'h0001);
        settle(4);
        chk(16'(n_irq), 16'h0000);
        wr(TFG_OFF_CONTROL, {13'h0000, TFG_PAT_STOP});
        repeat (120) @(posedge clk);
        #1;
        v = 16'(n_frm);
        chk(16'(rx.size() % 22), 16'h0000);
        repeat (200) @(posedge clk);
        chk(16'(n_frm), v);
        test_done("endless and stop");
        wr(TFG_OFF_CONTROL, 16'h0003);
        repeat (30) @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        #1;
        chk({6'h00, phy_tx_en, completion_irq, phy_txd}, 16'h0);
        @(posedge clk);
        rst <= 1'b0;
        rd(TFG_OFF_ENABLE);
        chk(v, 16'h0000);
        rd(TFG_OFF_PAY_LEN);
        chk(v, TFG_RST_PAY_LEN);
        test_done("reset");
        end_sim;
    end

endmodule

bind tfg_top tfg_chk u_tfg_chk (.clk(clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .mac_tx_en(mac_tx_en), .mac_txd(mac_txd),
    .phy_tx_strobe(phy_tx_strobe), .phy_tx_en(phy_tx_en),
    .phy_txd(phy_txd), .completion_irq(completion_irq));

`default_nettype wire
